// ==== hw/cpcd_top.sv ====
// configuration decoder: backplane jumpers into port operating settings
// assumes static jumpers on pins, one clock, plain register port
`include "cpcd_regs.svh"

module cpcd_top (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire cpcd_pkg::cpcd_jumpers_t jumpers,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output cpcd_pkg::cpcd_cfg_t cfg,
	output logic cfg_valid,
	output logic cfg_error,
	output logic irq
);

	cpcd_pkg::cpcd_jumpers_t sync1_reg, sync2_reg, sync3_reg;
	cpcd_pkg::cpcd_jumpers_t jmp_reg;
	cpcd_pkg::cpcd_state_t state_reg;
	logic [1:0] settle_reg;
	logic capture;
	logic qs_prog_mode_reg;
	logic [7:0] qs_prog_reg;
	logic [`CPCD_ST_W-1:0] status_reg, status_next;
	logic [`CPCD_ST_W-1:0] mask_reg;
	logic [`CPCD_ST_W-1:0] events;
	logic [`CPCD_ST_W-1:0] clear_bits;
	logic mismatch, rsv_addr, rsv_qs, rsv_cs;

	// boot time in seconds from the four-bit code
	function automatic logic [10:0] boot_secs(input logic [3:0] code);
		logic [10:0] step;
		step = 11'(code) * `CPCD_BOOT_STEP;
		return `CPCD_BOOT_MAX - step;
	endfunction

	// maximum cluster size from the three-bit code
	function automatic logic [7:0] cs_nodes(input logic [2:0] code);
		logic [7:0] n;
		n = `CPCD_CS_16;
		unique case (code)
			3'h0: n = `CPCD_CS_16;
			3'h1: n = `CPCD_CS_32;
			3'h2: n = `CPCD_CS_64;
			3'h3: n = `CPCD_CS_128;
			3'h4: n = `CPCD_CS_224;
			default: n = `CPCD_CS_16;
		endcase
		return n;
	endfunction

	// quiet-slot count from the three-bit code
	function automatic logic [7:0] qs_count(input logic [2:0] code, input logic [7:0] prog);
		logic [7:0] n;
		// reserved codes fall back to ten
		n = `CPCD_QS_TEN;
		if (code == `CPCD_QC_DEF) begin
			n = `CPCD_QS_DEF;
		end else if (code == `CPCD_QC_PROG) begin
			n = prog;
		end
		return n;
	endfunction

	// pin synchroniser, three stages
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= jumpers;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= cpcd_pkg::CPCD_SETTLING;
			settle_reg <= '0;
		end else begin
			unique case (state_reg)
				cpcd_pkg::CPCD_SETTLING: begin
					if (settle_reg == `CPCD_SETTLE) begin
						state_reg <= cpcd_pkg::CPCD_CAPTURE;
					end else begin
						settle_reg <= settle_reg + 2'h1;
					end
				end
				cpcd_pkg::CPCD_CAPTURE: begin
					if (sync2_reg == sync3_reg) begin
						state_reg <= cpcd_pkg::CPCD_HOLD;
					end
				end
				cpcd_pkg::CPCD_HOLD: begin
					state_reg <= cpcd_pkg::CPCD_HOLD;
				end
			endcase
		end
	end

	assign capture = (state_reg == cpcd_pkg::CPCD_CAPTURE) && (sync2_reg == sync3_reg);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			jmp_reg <= '0;
		end else if (capture) begin
			jmp_reg <= sync3_reg;
		end
	end

	assign mismatch = sync3_reg.node_addr_true_jumpers != sync3_reg.node_addr_compl_jumpers;
	assign rsv_addr = sync3_reg.node_addr_true_jumpers >= `CPCD_NODE_RSV_MIN;
	assign rsv_qs = sync3_reg.quiet_slot_jumpers != `CPCD_QC_DEF
		&& sync3_reg.quiet_slot_jumpers != `CPCD_QC_TEN
		&& sync3_reg.quiet_slot_jumpers != `CPCD_QC_PROG;
	assign rsv_cs = sync3_reg.cluster_size_jumpers > `CPCD_CC_MAX;

	// reset values are the no-jumper settings
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg.node_addr <= '0;
			cfg.boot_time_sec <= `CPCD_BOOT_MAX;
			cfg.arb_disable <= 1'b0;
			cfg.header_extend <= 1'b0;
			cfg.ack_timeout_extend <= 1'b0;
			cfg.cluster_size <= `CPCD_CS_16;
			cfg.quiet_slot_count <= `CPCD_QS_DEF;
		end else if (capture) begin
			cfg.node_addr <= sync3_reg.node_addr_true_jumpers;
			cfg.boot_time_sec <= boot_secs(sync3_reg.boot_time_jumpers);
			cfg.arb_disable <= sync3_reg.arb_disable_jumper;
			cfg.header_extend <= sync3_reg.header_extend_jumper;
			cfg.ack_timeout_extend <= sync3_reg.ack_timeout_extend_jumper;
			cfg.cluster_size <= cs_nodes(sync3_reg.cluster_size_jumpers);
			cfg.quiet_slot_count <= qs_count(sync3_reg.quiet_slot_jumpers, qs_prog_reg);
		end else if (qs_prog_mode_reg) begin
			cfg.quiet_slot_count <= qs_prog_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			qs_prog_mode_reg <= 1'b0;
		end else if (capture) begin
			qs_prog_mode_reg <= sync3_reg.quiet_slot_jumpers == `CPCD_QC_PROG;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_valid <= 1'b0;
			cfg_error <= 1'b0;
		end else if (capture) begin
			cfg_valid <= 1'b1;
			cfg_error <= mismatch | rsv_addr | rsv_qs | rsv_cs;
		end
	end

	// capture events into sticky status
	always_comb begin
		events = '0;
		events[`CPCD_ST_LOADED] = capture;
		events[`CPCD_ST_MISMATCH] = capture & mismatch;
		events[`CPCD_ST_RSV_ADDR] = capture & rsv_addr;
		events[`CPCD_ST_RSV_QS] = capture & rsv_qs;
		events[`CPCD_ST_RSV_CS] = capture & rsv_cs;
	end

	// write one to clear, a new event wins
	assign clear_bits = (reg_wr && reg_addr == `CPCD_OFS_STAT) ?
		reg_wdata[`CPCD_ST_W-1:0] : '0;
	assign status_next = (status_reg & ~clear_bits) | events;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// software-written registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mask_reg <= `CPCD_MASK_RST;
			qs_prog_reg <= `CPCD_QSPR_RST;
		end else if (reg_wr) begin
			if (reg_addr == `CPCD_OFS_MASK) begin
				mask_reg <= reg_wdata[`CPCD_ST_W-1:0];
			end
			if (reg_addr == `CPCD_OFS_QSPR) begin
				qs_prog_reg <= reg_wdata[7:0];
			end
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`CPCD_OFS_ADDR: reg_rdata <= {16'h0000,
					jmp_reg.node_addr_compl_jumpers, jmp_reg.node_addr_true_jumpers};
				// valid and error have pins of their own, the word starts at the modes
				`CPCD_OFS_MISC: reg_rdata <= {cfg.arb_disable, cfg.header_extend,
					cfg.ack_timeout_extend, cfg.boot_time_sec,
					jmp_reg.quiet_slot_jumpers, jmp_reg.cluster_size_jumpers,
					jmp_reg.boot_time_jumpers, cfg.quiet_slot_count};
				`CPCD_OFS_STAT: reg_rdata <= {27'h0, status_reg};
				`CPCD_OFS_MASK: reg_rdata <= {27'h0, mask_reg};
				`CPCD_OFS_QSPR: reg_rdata <= {24'h0, qs_prog_reg};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	assign irq = |(status_reg & mask_reg);

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	node_addr_a: assert property (
		$past(capture) |-> cfg.node_addr == $past(sync3_reg.node_addr_true_jumpers))
		else $error("node address not taken from true set");

	addr_match_a: assert property (
		capture && mismatch |=> cfg_error && status_reg[`CPCD_ST_MISMATCH])
		else $error("address set mismatch not flagged");

	rsv_addr_a: assert property (
		capture && sync3_reg.node_addr_true_jumpers >= 8'he0 |=> cfg_error)
		else $error("reserved node address not flagged");

	boot_time_a: assert property (
		capture |=> cfg.boot_time_sec ==
		11'd1500 - 11'd100 * 11'($past(sync3_reg.boot_time_jumpers)))
		else $error("boot time decode wrong");

	mode_bits_a: assert property (
		capture |=> {cfg.arb_disable, cfg.header_extend, cfg.ack_timeout_extend}
		== $past({sync3_reg.arb_disable_jumper, sync3_reg.header_extend_jumper,
		sync3_reg.ack_timeout_extend_jumper}))
		else $error("mode jumpers not applied");

	quiet_slot_a: assert property (
		capture && sync3_reg.quiet_slot_jumpers == 3'h1 |=> cfg.quiet_slot_count == 8'h0a)
		else $error("quiet slot code 001 not 10");

	cluster_size_a: assert property (
		capture && sync3_reg.cluster_size_jumpers == 3'h4 |=> cfg.cluster_size == 8'he0)
		else $error("cluster size code 4 not 224");

	defaults_a: assert property (
		capture && sync3_reg == '0 |=> cfg.quiet_slot_count == 8'h07
		&& cfg.cluster_size == 8'h10 && cfg.boot_time_sec == 11'd1500 && !cfg_error)
		else $error("no-jumper defaults wrong");

	hold_cfg_a: assert property (
		cfg_valid && !qs_prog_mode_reg |=> $stable(cfg) && cfg_valid)
		else $error("settings changed after capture");

	capture_once_a: assert property (
		capture |=> !capture [*8])
		else $error("jumpers captured twice");

	err_flag_a: assert property (
		capture && (rsv_qs || rsv_cs) |=> cfg_error ##0 (status_reg[4:3] != 2'h0))
		else $error("reserved code not flagged");

	irq_set_a: assert property (
		capture && mask_reg[0] |=> irq)
		else $error("masked-in load event gave no interrupt");

	load_c: cover property (capture ##1 cfg_valid && !cfg_error);
	mismatch_c: cover property (capture && mismatch);
	prog_qs_c: cover property (qs_prog_mode_reg && reg_wr && reg_addr == `CPCD_OFS_QSPR);
	clear_c: cover property (irq ##1 reg_wr && reg_addr == `CPCD_OFS_STAT ##1 !irq);

endmodule // cpcd_top

// ==== hw/cpcd_regs.svh ====
// constants of the cluster port configuration decoder
// assumes one clock domain and a plain register port with byte addresses
`ifndef CPCD_REGS_SVH
`define CPCD_REGS_SVH

// register byte offsets
`define CPCD_OFS_ADDR 8'h00
`define CPCD_OFS_MISC 8'h04
`define CPCD_OFS_STAT 8'h08
`define CPCD_OFS_MASK 8'h0c
`define CPCD_OFS_QSPR 8'h10

// status and mask bit positions
`define CPCD_ST_LOADED 0
`define CPCD_ST_MISMATCH 1
`define CPCD_ST_RSV_ADDR 2
`define CPCD_ST_RSV_QS 3
`define CPCD_ST_RSV_CS 4
`define CPCD_ST_W 5

// reset values
`define CPCD_MASK_RST 5'h00
`define CPCD_QSPR_RST 8'h0a

// decode constants
`define CPCD_NODE_RSV_MIN 8'he0
`define CPCD_BOOT_MAX 11'h5dc
`define CPCD_BOOT_STEP 11'h064
`define CPCD_QS_DEF 8'h07
`define CPCD_QS_TEN 8'h0a
`define CPCD_QC_DEF 3'h0
`define CPCD_QC_TEN 3'h1
`define CPCD_QC_PROG 3'h7
`define CPCD_CS_16 8'h10
`define CPCD_CS_32 8'h20
`define CPCD_CS_64 8'h40
`define CPCD_CS_128 8'h80
`define CPCD_CS_224 8'he0
`define CPCD_CC_MAX 3'h4
`define CPCD_SETTLE 2'h3

`endif

// ==== hw/cpcd_pkg.sv ====
// types of the cluster port configuration decoder
// assumes the constants header is compiled alongside
package cpcd_pkg;

	// jumper positions, installed reads as one, first jumper of a set is msb
	typedef struct packed {
		logic [7:0] node_addr_compl_jumpers;
		logic reserved_jumper;
		logic arb_disable_jumper;
		logic header_extend_jumper;
		logic ack_timeout_extend_jumper;
		logic [2:0] cluster_size_jumpers;
		logic [7:0] node_addr_true_jumpers;
		logic [3:0] boot_time_jumpers;
		logic [2:0] quiet_slot_jumpers;
	} cpcd_jumpers_t;

	// decoded operating settings
	typedef struct packed {
		logic [7:0] node_addr;
		logic [10:0] boot_time_sec;
		logic arb_disable;
		logic header_extend;
		logic ack_timeout_extend;
		logic [7:0] quiet_slot_count;
		logic [7:0] cluster_size;
	} cpcd_cfg_t;

	typedef enum logic [1:0] {
		CPCD_SETTLING,
		CPCD_CAPTURE,
		CPCD_HOLD
	} cpcd_state_t;

endpackage

// ==== verif/cpcd_jumper_model.sv ====
// partner model: the static backplane jumper field seen by the decoder
// assumes the bench sets the fitted pattern while the decoder is in reset, except one inversion after capture for the hold test
module cpcd_jumper_model (
	input wire cpcd_pkg::cpcd_jumpers_t fitted,
	output cpcd_pkg::cpcd_jumpers_t jumpers
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet count jumpers pass through as fitted, the bench sweeps 001 among all codes
	// reserved position is wired but carries no meaning
	assign jumpers = fitted;
endmodule // cpcd_jumper_model

// ==== verif/cpcd_top_tb.sv ====
// self-checking bench of the configuration decoder
// assumes the jumper model on the jumper pins and a plain register port
module cluster_port_config_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] rv;
	logic cfg_valid, cfg_error, irq;
	cpcd_pkg::cpcd_cfg_t cfg, held;
	cpcd_pkg::cpcd_jumpers_t fitted = '0;
	cpcd_pkg::cpcd_jumpers_t jumpers;
	int n_mismatch = 0;
	int total_checks = 0;

	initial forever #4 clk_sys = ~clk_sys;

	cpcd_jumper_model partner (.fitted(fitted), .jumpers(jumpers));
	cpcd_top dut (.clk_sys(clk_sys), .rstn(rstn), .jumpers(jumpers), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cfg(cfg), .cfg_valid(cfg_valid), .cfg_error(cfg_error), .irq(irq));

	function automatic cpcd_pkg::cpcd_cfg_t exp_cfg(cpcd_pkg::cpcd_jumpers_t j, logic [7:0] qp);
		cpcd_pkg::cpcd_cfg_t c;
		c.node_addr = j.node_addr_true_jumpers;
		c.boot_time_sec = 11'h5dc - 11'h064 * 11'(j.boot_time_jumpers);
		c.arb_disable = j.arb_disable_jumper;
		c.header_extend = j.header_extend_jumper;
		c.ack_timeout_extend = j.ack_timeout_extend_jumper;
		case (j.quiet_slot_jumpers)
			3'h0: c.quiet_slot_count = 8'h07;
			3'h7: c.quiet_slot_count = qp;
			default: c.quiet_slot_count = 8'h0a;
		endcase
		if (j.cluster_size_jumpers == 3'h4)
			c.cluster_size = 8'he0;
		else if (j.cluster_size_jumpers > 3'h4)
			c.cluster_size = 8'h10;
		else
			c.cluster_size = 8'h10 << j.cluster_size_jumpers;
		return c;
	endfunction

	// expected status word: loaded, mismatch, reserved node, reserved quiet, reserved size
	function automatic logic [31:0] exp_stat(cpcd_pkg::cpcd_jumpers_t j);
		logic qr;
		qr = !(j.quiet_slot_jumpers inside {3'h0, 3'h1, 3'h7});
		return {27'h0, j.cluster_size_jumpers > 3'h4, qr, j.node_addr_true_jumpers >= 8'he0,
			j.node_addr_true_jumpers != j.node_addr_compl_jumpers, 1'b1};
	endfunction

	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// resets with a jumper pattern, lets capture finish, checks decode and status
	task automatic boot(cpcd_pkg::cpcd_jumpers_t j, logic [4:0] m);
		logic [31:0] es;
		es = exp_stat(j);
		@(posedge clk_sys);
		rstn <= 1'b0;
		fitted <= j;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		// mask set while the decoder settles, so the capture events can interrupt
		wr(8'h0c, {27'h0, m});
		repeat (8) @(posedge clk_sys);
		#1;
		chk("cfg", 64'(exp_cfg(j, 8'h0a)), 64'(cfg));
		chk("cfg_valid", 64'h1, 64'(cfg_valid));
		chk("cfg_error", 64'(|es[4:1]), 64'(cfg_error));
		chk("irq", 64'(|(es[4:0] & m)), 64'(irq));
		rd(8'h08, rv);
		chk("status", 64'(exp_stat(j)), 64'(rv));
		rd(8'h00, rv);
		chk("addr reg", {48'h0, j.node_addr_compl_jumpers, j.node_addr_true_jumpers}, 64'(rv));
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_sys);
		n_mismatch++;
		results();
	end

	initial begin
		cpcd_pkg::cpcd_jumpers_t j;
		void'($urandom(9042));
		boot('0, 5'h00);
		chk("irq masked", 64'h0, 64'(irq));
		wr(8'h0c, 32'h1);
		chk("irq raised", 64'h1, 64'(irq));
		wr(8'h08, 32'h1);
		chk("irq cleared", 64'h0, 64'(irq));
		rd(8'h14, rv);
		chk("unmapped", 64'h0, 64'(rv));
		$display("test defaults done");
		for (int i = 0; i < 16; i++) begin
			j = '0;
			j.node_addr_true_jumpers = 8'(216 + i);
			j.node_addr_compl_jumpers = 8'(216 + i);
			j.quiet_slot_jumpers = 3'(i);
			j.cluster_size_jumpers = 3'(i);
			j.boot_time_jumpers = 4'(i);
			j.reserved_jumper = i[0];
			boot(j, 5'(i));
		end
		$display("test code tables done");
		for (int i = 0; i < 8; i++) begin
			j = cpcd_pkg::cpcd_jumpers_t'(30'($urandom));
			if (i[0])
				j.node_addr_compl_jumpers = j.node_addr_true_jumpers;
			boot(j, 5'($urandom));
		end
		$display("test random done");
		held = cfg;
		@(posedge clk_sys);
		fitted <= ~fitted;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("cfg held", 64'(held), 64'(cfg));
		$display("test hold done");
		j = '0;
		j.quiet_slot_jumpers = 3'h7;
		boot(j, 5'h00);
		wr(8'h10, 32'h33);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("programmed quiet", 64'(exp_cfg(j, 8'h33)), 64'(cfg));
		$display("test programmable done");
		results();
	end
endmodule // cluster_port_config_decoder_tb
